//--- logic/pcvr_regs.sv
// vendor control and status register bank of the port controller
`timescale 1ns/100ps
`default_nettype none

// Function
// - mask bits 4,3,2 block their interrupt when 0, pass when 1, reset 0.
// - select 0 clears flags by written one, select 1 clears after status read.
// - select governs alert, fault and vendor status, not frame start status.
// - writing message phy reset resets pd state machines, bit self clears.
// - message phy reset behaves as a received hard reset.
// - writing full device reset restores all defaults, bit self clears after.
// - toggling unattached samples pins each period, or only before toggle.
// - sample period 00 1ms, 01 2ms, 10 8ms, 11 16ms, reset 01.
// - source share 00 30%, 01 10%, 10 50%, 11 60% of period.
// - test carrier select 0 sends for fixed duration, 1 sends continuously.
// - writing fast role swap bit sends a fast role swap signal.
// - rx threshold follows power role, or the select field when overridden.
// - receive status shows preamble, crc good, frame end, frame start bits.
// - vendor status holds wake timer bit 4, line fault 3, overtemp 2.
module pcvr_regs #(
   parameter int CYCLES_PER_MS = pcvr_pkg::CYCLES_PER_MS,
   parameter int TEST_CARRIER_CYCLES = pcvr_pkg::TEST_CARRIER_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire pcvr_pkg::pcvr_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic wake_timer_event,
   input wire logic config_line_fault_event,
   input wire logic overtemp_event,
   input wire pcvr_pkg::pcvr_rx_stat_t rx_stat,
   input wire logic power_role_source,
   input wire logic toggle_active,
   input wire logic unattached,
   input wire logic toggle_imminent,
   input wire logic carrier_request,
   input wire logic carrier_stop,
   output logic vendor_irq,
   output logic read_clear_mode,
   output logic alert_status_read,
   output logic msg_phy_reset,
   output logic full_device_reset,
   output logic config_pin_sample,
   output logic [6:0] toggle_source_pct,
   output logic test_carrier_on,
   output logic fast_role_swap_send,
   output pcvr_pkg::pcvr_threshold_t rx_threshold
);

   // =====================================================
   // functions
   // cycles for a sample period code
   function automatic logic [23:0] period_cycles(input logic [1:0] code);
      logic [4:0] ms;
      ms = 5'h01;
      unique case (code)
         2'b00: ms = 5'h01;
         2'b01: ms = 5'h02;
         2'b10: ms = 5'h08;
         2'b11: ms = 5'h10;
      endcase
      period_cycles = 24'(CYCLES_PER_MS * int'(ms));
   endfunction

   // percent of the toggle period spent as source, per share code
   function automatic logic [6:0] share_pct(input logic [1:0] code);
      share_pct = 7'h1e;
      unique case (code)
         2'b00: share_pct = 7'h1e;
         2'b01: share_pct = 7'h0a;
         2'b10: share_pct = 7'h32;
         2'b11: share_pct = 7'h3c;
      endcase
   endfunction

   // =====================================================
   // storage and decode
   logic [4:0] irq_enable_q;
   logic [7:0] gen_ctrl_q;
   logic test_carrier_sel_q;
   logic frs_q;
   logic [3:0] rx_ctrl_q;
   logic [2:0] irq_status_q;
   logic [3:0] rx_stat_q;
   logic [7:0] reg_rdata_q;
   logic [4:0] msg_cnt_q;
   logic [4:0] full_cnt_q;
   logic [23:0] sample_cnt_q;
   logic [31:0] carrier_cnt_q;
   logic sample_q;
   pcvr_pkg::pcvr_carrier_state_t car_q;
   logic [6:0] pct_q;
   pcvr_pkg::pcvr_threshold_t thr_q;
   logic soft_rst;
   logic wr_en;
   logic wr_gen;
   logic rd_status;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;

   assign soft_rst = !rst_n || (full_cnt_q != 5'h00);
   assign wr_en = reg_req.wr && !soft_rst;
   assign wr_gen = wr_en && (reg_req.addr == pcvr_pkg::LINE_GENERAL_CONTROL_OFS);
   assign rd_status = reg_req.rd && (reg_req.addr == pcvr_pkg::VENDOR_IRQ_STATUS_OFS);

   // =====================================================
   // control registers, held at defaults during full device reset
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         irq_enable_q <= pcvr_pkg::VENDOR_IRQ_ENABLE_RST[4:0];
         gen_ctrl_q <= pcvr_pkg::LINE_GENERAL_CONTROL_RST;
         test_carrier_sel_q <= pcvr_pkg::BMC_TRANSMIT_CONTROL_RST[pcvr_pkg::TEST_CARRIER_SEL_BIT];
         rx_ctrl_q <= pcvr_pkg::BMC_RECEIVE_CONTROL_RST[3:0];
      end else if (wr_en) begin
         unique case (reg_req.addr)
            pcvr_pkg::VENDOR_IRQ_ENABLE_OFS: irq_enable_q <= reg_req.wdata[4:0];
            pcvr_pkg::LINE_GENERAL_CONTROL_OFS: begin
               gen_ctrl_q[pcvr_pkg::READ_CLEAR_MODE_BIT] <=
                  reg_req.wdata[pcvr_pkg::READ_CLEAR_MODE_BIT];
               gen_ctrl_q[4:0] <= reg_req.wdata[4:0];
            end
            pcvr_pkg::BMC_TRANSMIT_CONTROL_OFS:
               test_carrier_sel_q <= reg_req.wdata[pcvr_pkg::TEST_CARRIER_SEL_BIT];
            pcvr_pkg::BMC_RECEIVE_CONTROL_OFS: rx_ctrl_q <= reg_req.wdata[3:0];
            default: ;
         endcase
      end
   end

   // =====================================================
   // self clearing resets: bit reads one while its counter runs
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         msg_cnt_q <= 5'h00;
      end else if (wr_gen && reg_req.wdata[pcvr_pkg::MSG_PHY_RESET_BIT]) begin
         msg_cnt_q <= 5'(pcvr_pkg::MSG_PHY_RESET_CYCLES);
      end else if (msg_cnt_q != 5'h00) begin
         msg_cnt_q <= msg_cnt_q - 5'h01;
      end
   end

   // full reset counter, only cleared by the pin reset so the soft_rst it drives does not clear it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         full_cnt_q <= 5'h00;
      end else if (wr_gen && reg_req.wdata[pcvr_pkg::FULL_DEVICE_RESET_BIT]) begin
         full_cnt_q <= 5'(pcvr_pkg::FULL_DEVICE_RESET_CYCLES);
      end else if (full_cnt_q != 5'h00) begin
         full_cnt_q <= full_cnt_q - 5'h01;
      end
   end

   // =====================================================
   // vendor status flags, a new event wins over a clear
   assign irq_set = {wake_timer_event, config_line_fault_event, overtemp_event};
   // clear mask: read clears all in read mode, written ones clear otherwise
   always_comb begin
      irq_clr = 3'h0;
      if (gen_ctrl_q[pcvr_pkg::READ_CLEAR_MODE_BIT]) begin
         irq_clr = rd_status ? 3'h7 : 3'h0;
      end else if (wr_en && (reg_req.addr == pcvr_pkg::VENDOR_IRQ_STATUS_OFS)) begin
         irq_clr = reg_req.wdata[pcvr_pkg::WAKE_TIMER_BIT:pcvr_pkg::IRQ_FIELD_LO];
      end
   end

   // status flags, sticky until cleared
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         irq_status_q <= pcvr_pkg::VENDOR_IRQ_STATUS_RST;
      end else begin
         irq_status_q <= irq_set | (irq_status_q & ~irq_clr);
      end
   end

   // =====================================================
   // receive framing status, captured from the receiver
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         rx_stat_q <= 4'h0;
      end else begin
         rx_stat_q <= rx_stat;
      end
   end

   // =====================================================
   // fast role swap request, one cycle strobe
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         frs_q <= 1'b0;
      end else begin
         frs_q <= wr_en && (reg_req.addr == pcvr_pkg::BMC_TRANSMIT_CONTROL_OFS)
                  && reg_req.wdata[pcvr_pkg::FAST_ROLE_SWAP_BIT];
      end
   end

   // =====================================================
   // configuration pin sampling strobe
   always_ff @(posedge core_clk) begin
      if (soft_rst || !(toggle_active && unattached)) begin
         sample_cnt_q <= 24'h000000;
         sample_q <= 1'b0;
      end else if (gen_ctrl_q[pcvr_pkg::TOGGLE_SAMPLE_POLICY_BIT]) begin
         sample_cnt_q <= 24'h000000;
         sample_q <= toggle_imminent;
      end else if (sample_cnt_q + 24'h000001 >=
                   period_cycles(gen_ctrl_q[pcvr_pkg::SAMPLE_PERIOD_LO +: 2])) begin
         sample_cnt_q <= 24'h000000;
         sample_q <= 1'b1;
      end else begin
         sample_cnt_q <= sample_cnt_q + 24'h000001;
         sample_q <= 1'b0;
      end
   end

   // =====================================================
   // test carrier sequencer
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         car_q <= pcvr_pkg::PCVR_CAR_IDLE;
         carrier_cnt_q <= 32'h00000000;
      end else begin
         unique case (car_q)
            pcvr_pkg::PCVR_CAR_IDLE: begin
               carrier_cnt_q <= 32'(TEST_CARRIER_CYCLES);
               if (carrier_request) begin
                  car_q <= test_carrier_sel_q ? pcvr_pkg::PCVR_CAR_CONT
                                              : pcvr_pkg::PCVR_CAR_TIMED;
               end
            end
            pcvr_pkg::PCVR_CAR_TIMED: begin
               carrier_cnt_q <= carrier_cnt_q - 32'h00000001;
               if (carrier_stop || carrier_cnt_q <= 32'h00000001) begin
                  car_q <= pcvr_pkg::PCVR_CAR_IDLE;
               end
            end
            pcvr_pkg::PCVR_CAR_CONT: begin
               if (carrier_stop) begin
                  car_q <= pcvr_pkg::PCVR_CAR_IDLE;
               end
            end
            default: car_q <= pcvr_pkg::PCVR_CAR_IDLE;
         endcase
      end
   end

   // =====================================================
   // read data, registered on the read request
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         unique case (reg_req.addr)
            pcvr_pkg::VENDOR_IRQ_STATUS_OFS: reg_rdata_q <= {3'h0, irq_status_q, 2'h0};
            pcvr_pkg::VENDOR_IRQ_ENABLE_OFS: reg_rdata_q <= {3'h0, irq_enable_q};
            pcvr_pkg::LINE_GENERAL_CONTROL_OFS:
               reg_rdata_q <= {gen_ctrl_q[7], msg_cnt_q != 5'h00, full_cnt_q != 5'h00,
                               gen_ctrl_q[4:0]};
            pcvr_pkg::BMC_TRANSMIT_CONTROL_OFS: reg_rdata_q <= {5'h00, test_carrier_sel_q, 2'h0};
            pcvr_pkg::BMC_RECEIVE_CONTROL_OFS: reg_rdata_q <= {4'h0, rx_ctrl_q};
            pcvr_pkg::BMC_RECEIVE_STATUS_OFS: reg_rdata_q <= {4'h0, rx_stat_q};
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // =====================================================
   // outputs
   assign reg_rdata = reg_rdata_q;
   assign vendor_irq = |(irq_status_q & irq_enable_q[4:2]);
   assign read_clear_mode = gen_ctrl_q[pcvr_pkg::READ_CLEAR_MODE_BIT];
   assign alert_status_read = reg_req.rd; // lets alert and fault banks clear on read
   assign msg_phy_reset = msg_cnt_q != 5'h00;
   assign full_device_reset = full_cnt_q != 5'h00;
   assign config_pin_sample = sample_q;
   assign test_carrier_on = car_q != pcvr_pkg::PCVR_CAR_IDLE;
   assign fast_role_swap_send = frs_q;
   assign toggle_source_pct = pct_q;
   assign rx_threshold = thr_q;

   // source share percent, loaded at the same edge as the share field
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         pct_q <= share_pct(pcvr_pkg::LINE_GENERAL_CONTROL_RST[pcvr_pkg::TOGGLE_SHARE_LO +: 2]);
      end else if (wr_gen) begin
         pct_q <= share_pct(reg_req.wdata[pcvr_pkg::TOGGLE_SHARE_LO +: 2]);
      end
   end

   // receiver threshold, registered from the override field or the power role
   always_ff @(posedge core_clk) begin
      if (rx_ctrl_q[pcvr_pkg::RX_THRESHOLD_OVERRIDE_BIT]) begin
         thr_q <= pcvr_pkg::pcvr_threshold_t'(rx_ctrl_q[1:0]);
      end else if (power_role_source) begin
         thr_q <= pcvr_pkg::PCVR_THR_SOURCE;
      end else begin
         thr_q <= pcvr_pkg::PCVR_THR_SINK;
      end
   end

endmodule
`default_nettype wire

//--- logic/pcvr_pkg.sv
// package for the port controller vendor register bank: offsets, fields, resets, timing
`default_nettype none
package pcvr_pkg;
   // =====================================================
   // register offsets
   localparam logic [7:0] VENDOR_IRQ_STATUS_OFS = 8'h90;
   localparam logic [7:0] VENDOR_IRQ_ENABLE_OFS = 8'h92;
   localparam logic [7:0] LINE_GENERAL_CONTROL_OFS = 8'h94;
   localparam logic [7:0] BMC_TRANSMIT_CONTROL_OFS = 8'h95;
   localparam logic [7:0] BMC_RECEIVE_CONTROL_OFS = 8'h96;
   localparam logic [7:0] BMC_RECEIVE_STATUS_OFS = 8'h97;

   // =====================================================
   // reset values
   localparam logic [7:0] VENDOR_IRQ_ENABLE_RST = 8'h00;
   localparam logic [7:0] LINE_GENERAL_CONTROL_RST = 8'h04;
   localparam logic [7:0] BMC_TRANSMIT_CONTROL_RST = 8'h00;
   localparam logic [7:0] BMC_RECEIVE_CONTROL_RST = 8'h00;
   localparam logic [2:0] VENDOR_IRQ_STATUS_RST = 3'h0;

   // =====================================================
   // field positions
   localparam int WAKE_TIMER_BIT = 4;
   localparam int CONFIG_LINE_FAULT_BIT = 3;
   localparam int OVERTEMP_BIT = 2;
   localparam int IRQ_FIELD_LO = 2;
   localparam int READ_CLEAR_MODE_BIT = 7;
   localparam int MSG_PHY_RESET_BIT = 6;
   localparam int FULL_DEVICE_RESET_BIT = 5;
   localparam int TOGGLE_SAMPLE_POLICY_BIT = 4;
   localparam int SAMPLE_PERIOD_LO = 2;
   localparam int TOGGLE_SHARE_LO = 0;
   localparam int TEST_CARRIER_SEL_BIT = 2;
   localparam int FAST_ROLE_SWAP_BIT = 1;
   localparam int RX_THRESHOLD_OVERRIDE_BIT = 2;
   localparam int RX_THRESHOLD_SEL_LO = 0;

   // =====================================================
   // timing, core clock at 50 MHz
   localparam int CORE_CLK_KHZ = 50000;
   localparam int SAMPLE_UNIT_MS = 1;
   localparam int CYCLES_PER_MS = SAMPLE_UNIT_MS * CORE_CLK_KHZ;
   localparam int TEST_CARRIER_DURATION_MS = 50;  // plain default
   localparam int TEST_CARRIER_CYCLES = TEST_CARRIER_DURATION_MS * CORE_CLK_KHZ;
   localparam int MSG_PHY_RESET_CYCLES = 16;
   localparam int FULL_DEVICE_RESET_CYCLES = 16;

   // =====================================================
   // types
   typedef enum logic [1:0] {
      PCVR_THR_SINK = 2'b00,
      PCVR_THR_SOURCE = 2'b01,
      PCVR_THR_NEUTRAL = 2'b10,
      PCVR_THR_SINK_HI_SOURCE_LO = 2'b11
   } pcvr_threshold_t;

   typedef enum logic [2:0] {
      PCVR_CAR_IDLE = 3'b001,
      PCVR_CAR_TIMED = 3'b010,
      PCVR_CAR_CONT = 3'b100
   } pcvr_carrier_state_t;

   // register request from the serial slave front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcvr_reg_req_t;

   // receive framing status from the bmc receiver
   typedef struct packed {
      logic preamble;
      logic crc_good;
      logic frame_end;
      logic frame_start;
   } pcvr_rx_stat_t;
endpackage
`default_nettype wire

//--- sim/pcvr_regs_assertions.sv
// concurrent checks on the port side of the vendor register bank
`timescale 1ns/100ps
`default_nettype none
module pcvr_regs_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire pcvr_pkg::pcvr_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire pcvr_pkg::pcvr_rx_stat_t rx_stat,
   input wire logic toggle_active,
   input wire logic unattached,
   input wire logic carrier_request,
   input wire logic carrier_stop,
   input wire logic msg_phy_reset,
   input wire logic full_device_reset,
   input wire logic config_pin_sample,
   input wire logic [6:0] toggle_source_pct,
   input wire logic test_carrier_on,
   input wire logic fast_role_swap_send
);
   // ==========
   // clocking, reset-window and control write sequences
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_msg_hold;
      msg_phy_reset [*8];
   endsequence
   sequence s_full_hold;
      full_device_reset [*8];
   endsequence
   sequence s_ctl_write;
      reg_req.wr && reg_req.addr == 8'h94;
   endsequence

   // ==========
   // port relations
   a_frs_one_pulse: assert property (fast_role_swap_send |=> !fast_role_swap_send)
      else $error("fast role swap pulse longer than one cycle");
   a_frs_from_write: assert property ($rose(fast_role_swap_send) |-> $past(reg_req.wr)
      && $past(reg_req.addr) == 8'h95 && $past(reg_req.wdata[1]))
      else $error("fast role swap pulse without a write");
   a_msg_rst_start: assert property (s_ctl_write ##0 reg_req.wdata[6] && !msg_phy_reset
      && !full_device_reset |=> msg_phy_reset)
      else $error("message phy reset did not start");
   a_msg_rst_len: assert property ($rose(msg_phy_reset) |-> s_msg_hold ##1 s_msg_hold
      ##1 !msg_phy_reset)
      else $error("message phy reset length wrong");
   a_full_rst_start: assert property (s_ctl_write ##0 reg_req.wdata[5]
      && !full_device_reset |=> full_device_reset)
      else $error("full device reset did not start");
   a_full_rst_len: assert property ($rose(full_device_reset) |-> s_full_hold ##1 s_full_hold
      ##1 !full_device_reset)
      else $error("full device reset length wrong");
   a_sample_gated: assert property (config_pin_sample |-> $past(toggle_active)
      && $past(unattached))
      else $error("pin sample outside unattached toggling");
   a_carrier_start: assert property (carrier_request && !carrier_stop && !test_carrier_on
      && !full_device_reset |=> test_carrier_on)
      else $error("test carrier did not start");
   a_carrier_stop: assert property (carrier_stop && !carrier_request |=> !test_carrier_on)
      else $error("test carrier did not stop");
   a_rx_status_read: assert property (reg_req.rd && reg_req.addr == 8'h97
      && !full_device_reset && !$past(full_device_reset) |=> reg_rdata == {4'h0, $past(rx_stat, 2)})
      else $error("receive status read wrong");
   a_share_legal: assert property (toggle_source_pct inside {7'h1e, 7'h0a, 7'h32, 7'h3c})
      else $error("source share percent not a legal value");
endmodule
bind pcvr_regs pcvr_regs_assertions u_pcvr_regs_assertions (.core_clk, .rst_n, .reg_req,
   .reg_rdata, .rx_stat, .toggle_active, .unattached, .carrier_request, .carrier_stop,
   .msg_phy_reset, .full_device_reset, .config_pin_sample, .toggle_source_pct,
   .test_carrier_on, .fast_role_swap_send);
`default_nettype wire

//--- sim/pcvr_port_mgr.sv
// port manager model: issues single-byte register accesses
`timescale 1ns/100ps
`default_nettype none
module pcvr_port_mgr (
   input wire logic core_clk,
   output var pcvr_pkg::pcvr_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;

   // one access: request held over one edge, then released with scrambled address and data
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge core_clk);
      q = reg_rdata;
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the vendor register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int CPM = 10;
   localparam int TCC = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] ev = 3'h0;
   logic role = 1'b0, tg_act = 1'b0, unatt = 1'b0, tg_imm = 1'b0, c_req = 1'b0, c_stop = 1'b0;
   logic irq, rcm, msg_rst, full_rst, smp, frs, car_on, asr;
   logic [7:0] reg_rdata, d;
   logic [6:0] pct;
   pcvr_pkg::pcvr_reg_req_t reg_req;
   pcvr_pkg::pcvr_rx_stat_t rx_stat = 4'h0;
   pcvr_pkg::pcvr_threshold_t thr;
   logic [7:0] tbl_a [7] = '{8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h97};
   logic [7:0] tbl_v [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
   int errors = 0, n_compared = 0, cyc = 0, n_smp = 0, n_frs = 0, n, n_asr = 0, n_rd = 0;
   integer seed = 32'he2bdbbdd;

   pcvr_regs #(.CYCLES_PER_MS(CPM), .TEST_CARRIER_CYCLES(TCC)) u_pcvr_regs (
      .core_clk, .rst_n, .reg_req, .reg_rdata, .rx_stat,
      .wake_timer_event(ev[2]), .config_line_fault_event(ev[1]), .overtemp_event(ev[0]),
      .power_role_source(role), .toggle_active(tg_act), .unattached(unatt),
      .toggle_imminent(tg_imm), .carrier_request(c_req), .carrier_stop(c_stop),
      .vendor_irq(irq), .read_clear_mode(rcm), .alert_status_read(asr),
      .msg_phy_reset(msg_rst), .full_device_reset(full_rst), .config_pin_sample(smp),
      .toggle_source_pct(pct), .test_carrier_on(car_on), .fast_role_swap_send(frs),
      .rx_threshold(thr));
   pcvr_port_mgr u_pcvr_port_mgr (.core_clk, .reg_req, .reg_rdata);

   // ==========
   // clock, hang limit and pulse tallies
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      n_smp <= n_smp + int'(smp === 1'b1);
      n_frs <= n_frs + int'(frs === 1'b1);
      n_asr <= n_asr + int'(asr === 1'b1);
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end

   // ==========
   // expectations and helpers
   function automatic logic [7:0] exp_pct(input logic [1:0] s);
      return (s == 2'b00) ? 8'h1e : (s == 2'b01) ? 8'h0a : (s == 2'b10) ? 8'h32 : 8'h3c;
   endfunction
   function automatic logic [7:0] exp_ms(input logic [1:0] p);
      return (p == 2'b00) ? 8'h01 : (p == 2'b01) ? 8'h02 : (p == 2'b10) ? 8'h08 : 8'h10;
   endfunction
   function automatic logic [7:0] exp_thr(input logic ov, input logic [1:0] s, input logic r);
      return ov ? {6'h0, s} : {7'h0, r};
   endfunction
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] x;
      u_pcvr_port_mgr.access(1'b1, a, v, x);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x;
      n_rd++;
      u_pcvr_port_mgr.access(1'b0, a, 8'h00, x);
      chk(what, e, x);
   endtask
   task automatic pulse_ev(input logic [2:0] m);
      ev <= m;
      @(posedge core_clk);
      ev <= 3'h0;
      @(posedge core_clk);
   endtask
   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while (smp !== 1'b1 && c < 400);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 7; i++) rdc("reset", tbl_a[i], tbl_v[i]);
      chk("pct reset", 8'h1e, {1'b0, pct});
      // random enables, one event each, write-one clearing
      for (int k = 0; k < 9; k++) begin
         d = 8'($random(seed));
         wr(8'h92, d);
         rdc("enable", 8'h92, d & 8'h1f);
         pulse_ev(3'b001 << (k % 3));
         chk("irq", {7'h0, d[k % 3 + 2]}, {7'h0, irq});
         rdc("status", 8'h90, 8'h04 << (k % 3));
         rdc("no read clear", 8'h90, 8'h04 << (k % 3));
         wr(8'h90, 8'h1c);
         rdc("w1c", 8'h90, 8'h00);
         chk("irq off", 8'h00, {7'h0, irq});
      end
      // clear-on-read mode
      wr(8'h94, 8'h85);
      chk("mode", 8'h01, {7'h0, rcm});
      pulse_ev(3'b111);
      rdc("rd status", 8'h90, 8'h1c);
      rdc("rd cleared", 8'h90, 8'h00);
      // event in the same cycle as a clearing read: the set wins
      ev <= 3'b100;
      fork
         rdc("rd with event", 8'h90, 8'h00);
         begin
            @(posedge core_clk);
            ev <= 3'h0;
         end
      join
      rdc("set wins", 8'h90, 8'h10);
      // share decode and sampling period per field value
      tg_act <= 1'b1;
      unatt <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         wr(8'h94, {4'h0, 2'(p), 2'(p)});
         chk("share", exp_pct(2'(p)), {1'b0, pct});
         gap(n);
         gap(n);
         chk("period", 8'(exp_ms(2'(p)) * CPM), 8'(n));
      end
      // sample only before a role toggle
      wr(8'h94, 8'h10);
      tg_imm <= 1'b1;
      @(posedge core_clk);
      tg_imm <= 1'b0;
      @(posedge core_clk);
      chk("toggle sample", 8'h01, {7'h0, smp});
      repeat (2) @(posedge core_clk);
      n = n_smp;
      repeat (40) @(posedge core_clk);
      chk("no periodic", 8'(n), 8'(n_smp));
      tg_act <= 1'b0;
      unatt <= 1'b0;
      // receive threshold against role and override
      for (int i = 0; i < 8; i++) begin
         role <= 1'($random(seed));
         wr(8'h96, 8'(i));
         rdc("rx ctl", 8'h96, 8'(i));
         chk("thr", exp_thr(i[2], i[1:0], role), {6'h0, thr});
      end
      // timed and continuous test carrier
      for (int s = 0; s < 2; s++) begin
         wr(8'h95, 8'(s * 4));
         c_req <= 1'b1;
         @(posedge core_clk);
         c_req <= 1'b0;
         n = 0;
         repeat (60) begin
            @(posedge core_clk);
            n += int'(car_on === 1'b1);
         end
         chk("carrier", (s == 1) ? 8'h3c : 8'(TCC), 8'(n));
         c_stop <= 1'b1;
         @(posedge core_clk);
         c_stop <= 1'b0;
         repeat (2) @(posedge core_clk);
         chk("carrier off", 8'h00, {7'h0, car_on});
      end
      // fast role swap, self-clearing
      n = n_frs;
      wr(8'h95, 8'h02);
      repeat (3) @(posedge core_clk);
      chk("frs pulses", 8'(n + 1), 8'(n_frs));
      rdc("frs bit", 8'h95, 8'h00);
      // message phy reset
      wr(8'h94, 8'h44);
      chk("msg rst", 8'h01, {7'h0, msg_rst});
      rdc("msg bit", 8'h94, 8'h44);
      repeat (20) @(posedge core_clk);
      rdc("msg done", 8'h94, 8'h04);
      // full device reset, ignored write, then reprogramming
      wr(8'h92, 8'h1c);
      wr(8'h94, 8'h2b);
      chk("full rst", 8'h01, {7'h0, full_rst});
      rdc("full bit", 8'h94, 8'h24);
      wr(8'h92, 8'h1c);
      repeat (20) @(posedge core_clk);
      for (int i = 0; i < 7; i++) rdc("after full", tbl_a[i], tbl_v[i]);
      wr(8'h92, 8'h1c);
      rdc("reprog", 8'h92, 8'h1c);
      // receive framing status
      for (int k = 0; k < 8; k++) begin
         rx_stat <= 4'($random(seed));
         @(posedge core_clk);
         rdc("rx status", 8'h97, {4'h0, rx_stat});
      end
      chk("read strobes", 8'(n_rd), 8'(n_asr));
      end_of_test();
   end
endmodule
`default_nettype wire
